// ### verif/sac_adc_ctrl_assertions.sv
`timescale 1ns/1ps
module sac_adc_ctrl_assertions #(
	parameter RES_BITS = 10
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [31:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire pslverr,
	input wire standbyReq,
	input wire sampleHold,
	input wire ladderOn,
	input wire [2:0] channelSelect,
	input wire channelValid,
	input wire analogInputEnable,
	input wire [RES_BITS-1:0] dacCode,
	input wire conversionDoneIrq_q
);
	wire acc = psel && penable;
	wire wr1 = acc && pwrite && !standbyReq && paddr == 32'h38;
	wire wr2 = acc && pwrite && !standbyReq && paddr == 32'h3c;
	reg tcZero_q;
	// Time code is tracked so only the shortest length is timed exactly.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tcZero_q <= 1'b1;
		else if (standbyReq)
			tcZero_q <= 1'b1;
		else if (wr2)
			tcZero_q <= pwdata[3:1] == 3'h0;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence startSingle;
		wr1 && pwdata[7] && pwdata[6:5] == 2'h1;
	endsequence
	a_start_samples: assert property (
		startSingle |=> ##1 sampleHold && ladderOn)
		else $error("No sampling after a start write.");
	a_done_time: assert property (
		startSingle ##0 tcZero_q |-> ##[40:42] conversionDoneIrq_q)
		else $error("Shortest conversion did not finish on time.");
	a_done_early: assert property (
		startSingle |=> !conversionDoneIrq_q [*8])
		else $error("Conversion finished too early.");
	a_irq_pulse: assert property (
		conversionDoneIrq_q |=> !conversionDoneIrq_q)
		else $error("Done pulse longer than one cycle.");
	a_input_enable: assert property (
		wr1 |=> analogInputEnable == !$past(pwdata[4]))
		else $error("Input enable does not follow its bit.");
	a_channel_route: assert property (
		wr1 |=> channelSelect == $past(pwdata[2:0]) &&
		channelValid == !$past(pwdata[3]))
		else $error("Channel routing wrong.");
	a_ladder_hold: assert property (
		wr2 && pwdata[5] |=> ladderOn)
		else $error("Ladder not held connected.");
	a_standby_init: assert property (
		standbyReq |=> channelSelect == 3'h0 && channelValid &&
		!analogInputEnable)
		else $error("Standby did not restore control one.");
	a_stop_quiet: assert property (
		wr1 && pwdata[6:5] == 2'h0 |=> !conversionDoneIrq_q [*8])
		else $error("Done pulse after a stop.");
	a_unmapped_err: assert property (
		acc |-> pslverr == !(paddr == 32'h38 || paddr == 32'h3c ||
		paddr == 32'h80 || paddr == 32'h84))
		else $error("Error response wrong for address.");
	a_dac_midscale: assert property (
		sampleHold |-> dacCode == {1'b1, {(RES_BITS-1){1'b0}}})
		else $error("Trial code not at midscale while sampling.");
endmodule // sac_adc_ctrl_assertions
bind sac_adc_ctrl sac_adc_ctrl_assertions #(
	.RES_BITS(RES_BITS)
) u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pwdata(pwdata),
	.pslverr(pslverr),
	.standbyReq(standbyReq),
	.sampleHold(sampleHold),
	.ladderOn(ladderOn),
	.channelSelect(channelSelect),
	.channelValid(channelValid),
	.analogInputEnable(analogInputEnable),
	.dacCode(dacCode),
	.conversionDoneIrq_q(conversionDoneIrq_q)
);

// ### verif/sac_analog_model.sv
`timescale 1ns/1ps
module sac_analog_model (
	input wire clk_sys,
	input wire [9:0] level,
	input wire [9:0] dacCode,
	input wire sampleHold,
	output wire compHigh
);
	reg [9:0] heldLevel_q = 10'h000;
	// The hold node tracks the input only in the sample slot.
	always @(posedge clk_sys) begin
		if (sampleHold)
			heldLevel_q <= level;
	end
	// Comparator is high while the held input is at or above the trial code.
	assign compHigh = heldLevel_q >= dacCode;
endmodule // sac_analog_model

// ### verif/tb_sar_adc_control.sv
`timescale 1ns/1ps
module tb_sar_adc_control;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg [31:0] paddr = 32'h0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [31:0] pwdata = 32'h0;
	reg standbyReq = 1'b0;
	reg [9:0] level = 10'h2c9;
	wire [31:0] prdata;
	wire pready, pslverr, compHigh, sampleHold, ladderOn, chValid, inEn, irq;
	wire [9:0] dacCode;
	wire [2:0] chSel;
	int n_mismatch = 0;
	int n_checks = 0;
	int base, cnt, k;
	logic [31:0] rd;
	logic err;
	int lenTab[7] = '{39, 78, 156, 312, 624, 1248, 1248};
	int codeTab[7] = '{0, 2, 3, 4, 5, 6, 7};
	// Clock of 25 ns.
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	sac_adc_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standbyReq(standbyReq),
		.compHigh(compHigh), .dacCode(dacCode),
		.sampleHold(sampleHold), .ladderOn(ladderOn),
		.channelSelect(chSel), .channelValid(chValid),
		.analogInputEnable(inEn), .conversionDoneIrq_q(irq));
	sac_analog_model u_model (.clk_sys(clk_sys), .level(level),
		.dacCode(dacCode), .sampleHold(sampleHold), .compHigh(compHigh));
	task give_verdict;
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer; an idle cycle precedes each setup phase.
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			give_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Counts edges up to the done pulse; a long wait ends the run.
	task waitIrq;
		cnt = 0;
		do begin
			@(posedge clk_sys);
			cnt++;
		end while (irq !== 1'b1 && cnt < 3000);
		if (irq !== 1'b1) begin
			n_mismatch++;
			give_verdict;
		end
	endtask
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(0, 32'h38, 0);
		chk("ctrl one reset", 32'h10, rd);
		apb(0, 32'h84, 0);
		chk("result high reset", 32'h0, rd);
		apb(1, 32'h3c, 32'h30);
		apb(0, 32'h3c, 0);
		chk("ctrl two", 32'h30, rd & 32'h3f);
		apb(0, 32'h40, 0);
		chk("unmapped error", 32'h1, {31'h0, err});
		// Each time code, one reserved too, is timed against the shortest.
		for (k = 0; k < 7; k++) begin
			apb(1, 32'h3c, 32'h10 | (codeTab[k] << 1));
			apb(1, 32'h38, 32'ha3);
			waitIrq;
			if (k == 0)
				base = cnt;
			chk("conversion length", lenTab[k] - 39, cnt - base);
		end
		apb(0, 32'h38, 0);
		chk("start clear", 32'h23, rd);
		apb(0, 32'h80, 0);
		chk("result low", 32'h60, rd & 32'hf0);
		apb(0, 32'h84, 0);
		chk("result high", 32'hb2, rd);
		apb(0, 32'h80, 0);
		chk("end flag clear", 32'h40, rd & 32'hf0);
		apb(1, 32'h38, 32'hc3);
		apb(0, 32'h80, 0);
		chk("reserved mode", 32'h40, rd & 32'hf0);
		apb(1, 32'h3c, 32'h1c);
		level <= 10'h156;
		apb(1, 32'h38, 32'he3);
		apb(0, 32'h80, 0);
		chk("busy old result", 32'h50, rd & 32'hf0);
		waitIrq;
		waitIrq;
		apb(0, 32'h80, 0);
		chk("repeat running", 32'hb0, rd & 32'hf0);
		apb(1, 32'h38, 32'h03);
		apb(0, 32'h80, 0);
		chk("stopped busy", 32'h0, rd & 32'h10);
		apb(0, 32'h84, 0);
		chk("kept result", 32'h55, rd);
		apb(1, 32'h38, 32'h1b);
		apb(0, 32'h38, 0);
		chk("ctrl one", 32'h1b, rd);
		apb(1, 32'h38, 32'ha3);
		apb(0, 32'h80, 0);
		chk("busy set", 32'h90, rd & 32'hf0);
		standbyReq <= 1'b1;
		apb(1, 32'h38, 32'h05);
		apb(0, 32'h38, 0);
		chk("standby ctrl one", 32'h10, rd);
		apb(0, 32'h84, 0);
		chk("standby result", 32'h0, rd);
		apb(0, 32'h80, 0);
		chk("standby flags", 32'h0, rd & 32'hf0);
		standbyReq <= 1'b0;
		give_verdict;
	end
endmodule // tb_sar_adc_control

// ### verilog/sac_adc_ctrl.v
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "sac_regs.vh"
module sac_adc_ctrl #(
	parameter RES_BITS = 10
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [31:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire standbyReq,
	input wire compHigh,
	output wire [RES_BITS-1:0] dacCode,
	output wire sampleHold,
	output wire ladderOn,
	output wire [2:0] channelSelect,
	output wire channelValid,
	output wire analogInputEnable,
	output reg conversionDoneIrq_q
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SAMPLE = 3'b010;
	localparam ST_CONV = 3'b100;

	reg rstMeta_q;
	reg rstSync_q;
	wire rstSync_n;
	reg [7:0] ctrl1_q;
	reg [7:0] ctrl2_q;
	reg [7:0] resHigh_q;
	reg [1:0] resLow_q;
	reg endFlag_q;
	reg busy_q;
	reg [2:0] state_q;
	reg [11:0] cnt_q;
	reg [11:0] convLen;
	reg [11:0] stepLen;
	reg [3:0] stepCnt_q;
	reg [3:0] noise_q;
	reg [31:0] stepWide;
	reg [31:0] rdMux;
	wire [RES_BITS-1:0] trial;
	wire [7:0] word;
	wire rdSetup;
	wire access;
	wire wrEn;
	wire rdEn;
	wire [1:0] mode;
	wire startReq;
	wire beginConv;
	wire abortConv;
	wire stepTick;
	wire finish;
	wire known;

	// Reset is released through two flops so deassertion is clean.
	// Assertion stays asynchronous so the block clears with no clock, and
	// every other flop sees only the synchronised copy.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign rstSync_n = rstSync_q;

	// Zero-wait APB slave; unmapped or unaligned words answer with error.
	// Read data is captured in the setup cycle so that it leaves a flop;
	// side effects of a read still happen only in the access cycle.
	// Every transfer finishes in its access cycle, as pready is tied high.
	assign access = psel && penable;
	assign rdSetup = psel && !penable && !pwrite && known;
	assign word = paddr[9:2];
	assign known = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0) &&
		(word == `SAC_IDX_CTRL1 || word == `SAC_IDX_CTRL2 ||
		word == `SAC_IDX_RESLO || word == `SAC_IDX_RESHI);
	assign pready = 1'b1;
	assign pslverr = access && !known;
	assign wrEn = access && pwrite && known;
	assign rdEn = access && !pwrite && known;
	assign mode = ctrl1_q[`SAC_C1_MODE_HI:`SAC_C1_MODE_LO];

	// Time code to cycle count; reserved codes fall back to the longest.
	// Falling back to the slowest time keeps a bad code from overclocking.
	always @* begin
		case (ctrl2_q[3:1])
			3'b000: convLen = `SAC_CYC_000;
			3'b010: convLen = `SAC_CYC_010;
			3'b011: convLen = `SAC_CYC_011;
			3'b100: convLen = `SAC_CYC_100;
			3'b101: convLen = `SAC_CYC_101;
			3'b110: convLen = `SAC_CYC_110;
			default: convLen = `SAC_CYC_110;
		endcase
		// One sample slot plus one slot per bit, leftover goes to the end.
		// The quotient never exceeds the length, so the top bits are zero.
		stepWide = convLen / (RES_BITS + 1);
		stepLen = stepWide[11:0];
	end

	// A start only counts in a valid operating mode; 10 is ignored.
	// Mode 00 aborts at once and discards the partial result.
	assign startReq = ctrl1_q[`SAC_C1_START] &&
		(mode == `SAC_MODE_SINGLE || mode == `SAC_MODE_REPEAT);
	assign abortConv = standbyReq || mode == `SAC_MODE_OFF;
	assign finish = (state_q == ST_CONV) && (cnt_q == convLen - 12'd1);
	assign beginConv = !abortConv && ((state_q == ST_IDLE && startReq) ||
		(finish && mode == `SAC_MODE_REPEAT));
	assign stepTick = (state_q != ST_IDLE) && (stepCnt_q == 4'd0) &&
		(cnt_q != 12'd0);

	// Control registers: standby forces reset values and blocks writes.
	// Only bits 5:0 of control two are kept; bits 7:6 read as noise.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ctrl1_q <= `SAC_CTRL1_RST;
			ctrl2_q <= `SAC_CTRL2_RST;
		end else if (standbyReq) begin
			ctrl1_q <= `SAC_CTRL1_RST;
			ctrl2_q <= `SAC_CTRL2_RST;
		end else begin
			if (wrEn && word == `SAC_IDX_CTRL1)
				ctrl1_q <= pwdata[7:0];
			else if (state_q == ST_IDLE && startReq)
				ctrl1_q[`SAC_C1_START] <= 1'b0;
			else if (!startReq)
				ctrl1_q[`SAC_C1_START] <= 1'b0;
			if (wrEn && word == `SAC_IDX_CTRL2)
				ctrl2_q <= {2'b00, pwdata[5:0]};
		end
	end

	// Sequencer: sample window then one slot per bit over the set time.
	// The first slot holds the input; each later slot boundary resolves
	// one bit. The finish edge comes exactly the set length after the
	// start edge, whatever is left after the last bit is idle time.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 12'd0;
			stepCnt_q <= 4'd0;
		end else if (abortConv) begin
			state_q <= ST_IDLE;
			cnt_q <= 12'd0;
			stepCnt_q <= 4'd0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (beginConv) begin
						state_q <= ST_SAMPLE;
						cnt_q <= 12'd0;
						stepCnt_q <= 4'd0;
					end
				end
				ST_SAMPLE, ST_CONV: begin
					if (finish && !beginConv) begin
						state_q <= ST_IDLE;
						cnt_q <= 12'd0;
					end else if (finish) begin
						state_q <= ST_SAMPLE;
						cnt_q <= 12'd0;
						stepCnt_q <= 4'd0;
					end else begin
						cnt_q <= cnt_q + 12'd1;
						if (cnt_q + 12'd1 >= stepLen)
							state_q <= ST_CONV;
						if ((cnt_q + 12'd1) % stepLen == 12'd0)
							stepCnt_q <= 4'd0;
						else
							stepCnt_q <= 4'd1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// The trial code drives the DAC directly; the mask stays inside.
	sac_sar_step #(
		.WIDTH(RES_BITS)
	) u_sar (
		.clk_sys(clk_sys),
		.rstSync_n(rstSync_n),
		.begin_i(beginConv),
		.abort_i(abortConv),
		.step_i(stepTick && state_q == ST_CONV),
		.compHigh(compHigh),
		.trial_q(trial),
		.mask_q()
	);

	// Results, end flag, busy flag and done pulse; completion wins a read.
	// A read of the high result that meets a completion in its access cycle leaves
	// the flag set; the flag of a completion in its setup cycle is cleared by the read.
	// Standby wipes the results as well, so read them before entering it.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			resHigh_q <= 8'h00;
			resLow_q <= 2'b00;
			endFlag_q <= 1'b0;
			busy_q <= 1'b0;
			conversionDoneIrq_q <= 1'b0;
		end else begin
			conversionDoneIrq_q <= 1'b0;
			if (standbyReq) begin
				resHigh_q <= 8'h00; // earlier results are lost in standby
				resLow_q <= 2'b00;
				endFlag_q <= 1'b0;
				busy_q <= 1'b0;
			end else if (finish && !abortConv) begin
				resHigh_q <= trial[RES_BITS-1:RES_BITS-8];
				resLow_q <= trial[1:0];
				endFlag_q <= 1'b1;
				conversionDoneIrq_q <= 1'b1;
				busy_q <= beginConv;
			end else begin
				if (beginConv)
					endFlag_q <= 1'b0;
				else if (rdEn && word == `SAC_IDX_RESHI)
					endFlag_q <= 1'b0;
				if (beginConv)
					busy_q <= 1'b1;
				else if (abortConv)
					busy_q <= 1'b0;
			end
		end
	end

	// Free-running scramble so the low nibble is visibly meaningless.
	// It is not a random source and must never be used as one.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			noise_q <= 4'h1;
		else
			noise_q <= {noise_q[2:0], noise_q[3] ^ noise_q[2]};
	end

	// Read data mux; flags are read-only since writes never reach them.
	always @* begin
		rdMux = 32'h0000_0000;
		if (rdSetup) begin
			case (word)
				`SAC_IDX_CTRL1: rdMux = {24'h0, ctrl1_q};
				`SAC_IDX_CTRL2: rdMux = {24'h0, noise_q[1:0],
					ctrl2_q[5:0]};
				`SAC_IDX_RESLO: rdMux = {24'h0, resLow_q, endFlag_q,
					busy_q, noise_q};
				`SAC_IDX_RESHI: rdMux = {24'h0, resHigh_q};
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	// Read data register: loaded in setup, standing through the access.
	// A completion in the access cycle shows on the next read instead.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n)
			prdata <= 32'h0000_0000;
		else
			prdata <= rdMux;
	end

	// Analog front-end controls.
	// The ladder stays off outside conversions unless held on, saving current.
	assign dacCode = trial;
	assign sampleHold = (state_q == ST_SAMPLE);
	assign ladderOn = ctrl2_q[`SAC_C2_LADDER] || busy_q;
	assign channelSelect = ctrl1_q[2:0];
	assign channelValid = !ctrl1_q[3];
	assign analogInputEnable = !ctrl1_q[`SAC_C1_AINDIS];
endmodule // sac_adc_ctrl

// ### verilog/sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// Register indices; the byte address is four times the index.
`define SAC_IDX_CTRL1 8'h0e
`define SAC_IDX_CTRL2 8'h0f
`define SAC_IDX_RESLO 8'h20
`define SAC_IDX_RESHI 8'h21
// Reset values of the control registers.
`define SAC_CTRL1_RST 8'h10
`define SAC_CTRL2_RST 8'h10
// Field positions in control register one.
`define SAC_C1_START 7
`define SAC_C1_MODE_HI 6
`define SAC_C1_MODE_LO 5
`define SAC_C1_AINDIS 4
// Field positions in control register two.
`define SAC_C2_LADDER 5
// Operating modes.
`define SAC_MODE_OFF 2'b00
`define SAC_MODE_SINGLE 2'b01
`define SAC_MODE_REPEAT 2'b11
// Conversion lengths in fc cycles.
`define SAC_CYC_000 12'd39
`define SAC_CYC_010 12'd78
`define SAC_CYC_011 12'd156
`define SAC_CYC_100 12'd312
`define SAC_CYC_101 12'd624
`define SAC_CYC_110 12'd1248
`endif

// ### verilog/sac_sar_step.v
`timescale 1ns/1ps
// Successive approximation register: one trial bit per step, MSB first.
module sac_sar_step #(
	parameter WIDTH = 10
) (
	input wire clk_sys,
	input wire rstSync_n,
	input wire begin_i,
	input wire abort_i,
	input wire step_i,
	input wire compHigh,
	output reg [WIDTH-1:0] trial_q,
	output reg [WIDTH-1:0] mask_q
);
	// Trial bit kept when comparator says input is above the DAC level.
	always @(posedge clk_sys or negedge rstSync_n) begin
		if (!rstSync_n) begin
			trial_q <= {WIDTH{1'b0}};
			mask_q <= {WIDTH{1'b0}};
		end else if (abort_i) begin
			trial_q <= {WIDTH{1'b0}};
			mask_q <= {WIDTH{1'b0}};
		end else if (begin_i) begin
			mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
			trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (step_i && mask_q != {WIDTH{1'b0}}) begin
			if (!compHigh)
				trial_q <= (trial_q & ~mask_q) | (mask_q >> 1);
			else
				trial_q <= trial_q | (mask_q >> 1);
			mask_q <= mask_q >> 1;
		end
	end
endmodule // sac_sar_step
